/* dv/lio_host_model.sv */
`timescale 1ns/100ps
module lio_host_model
(
  input wire logic clk,
  input wire logic par_on,
  output logic spi_wr_valid,
  output logic [4:0] spi_wr_addr,
  output logic spi_wr_parity,
  output logic [7:0] spi_wr_data
);
  initial
  begin
    spi_wr_valid = 1'b0;
    spi_wr_addr = 5'h00;
    spi_wr_parity = 1'b0;
    spi_wr_data = 8'h00;
  end

  // One write pulse; bad flips the parity so that a refusal can be provoked.
  task automatic send(input logic [4:0] a, input logic [7:0] d, input logic bad);
  begin
    @(posedge clk);
    #2;
    spi_wr_valid = 1'b1;
    spi_wr_addr = a;
    spi_wr_data = d;
    spi_wr_parity = (par_on ? ^{a, d} : 1'b0) ^ bad;
    @(posedge clk);
    #2;
    spi_wr_valid = 1'b0;
    // Released lines show a changed value so a late sample cannot pass by luck.
    spi_wr_addr = ~a;
    spi_wr_data = ~d;
  end
  endtask : send
endmodule : lio_host_model

/* dv/tb_lio_top.sv */
`timescale 1ns/100ps
module tb_lio_top;
  import lio_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic par_on = 1'b0;
  logic init_mode = 1'b1;
  logic lpm = 1'b0;
  logic cyc_en = 1'b0;
  logic cyc_act = 1'b0;
  logic mcu_ov = 1'b0;
  logic aux_ov = 1'b0;
  logic [3:0] req = 4'h0;
  logic valid;
  logic parity;
  logic [4:0] addr;
  logic [7:0] data;
  logic [7:0] setup;
  lio_pin_fn_type fn1;
  lio_pin_fn_type fn2;
  wire [3:0] dec;
  wire [3:0] drv;
  logic wr_done;
  logic wr_refused;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] rows_in [8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h40, 8'h60, 8'h48};
  logic [3:0] rows_dec [8] = '{4'h0, 4'h2, 4'h1, 4'h0, 4'h8, 4'h4, 4'h0, 4'h6};

  always #20 clk = ~clk;

  lio_host_model host (.clk(clk), .par_on(par_on), .spi_wr_valid(valid),
    .spi_wr_addr(addr), .spi_wr_parity(parity), .spi_wr_data(data));

  lio_top dut (.clk(clk), .srst(srst), .ce(ce), .spi_wr_valid(valid),
    .spi_wr_addr(addr), .spi_wr_parity(parity), .spi_wr_data(data),
    .parity_check_en(par_on), .init_mode(init_mode), .low_power_mode(lpm),
    .cyclic_sense_en(cyc_en), .cyclic_active(cyc_act), .mcu_supply_ov(mcu_ov),
    .auxiliary_supply_ov(aux_ov), .io0_high_req(req[3]), .io0_low_req(req[2]),
    .io1_high_req(req[1]), .io1_low_req(req[0]), .lin_io_pin_setup(setup),
    .lin_pin1_function(fn1), .lin_pin2_function(fn2),
    .lin1_master_switch(dec[1]), .lin1_high_wake(dec[0]),
    .lin2_master_switch(dec[3]), .lin2_high_wake(dec[2]),
    .io0_high_side_driver(drv[3]), .io0_low_side_driver(drv[2]),
    .io1_high_side_driver(drv[1]), .io1_low_side_driver(drv[0]),
    .wr_done(wr_done), .wr_refused(wr_refused));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk

  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge clk);
    #2;
  end
  endtask : cyc

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : test_done

  // Writes a setup byte and checks that it was taken.
  task automatic wr(input logic [7:0] d);
  begin
    host.send(LIO_SETUP_ADDR, d, 1'b0);
    chk("wr_done", 8'h01, {7'h00, wr_done});
    chk("setup", d, setup);
  end
  endtask : wr

  initial
  begin
    #1ms;
    mismatches++;
    $display("[ERR] run time expected end seen limit");
    test_done();
  end

  initial
  begin
    cyc(12);
    srst = 1'b0;
    chk("setup", LIO_SETUP_RESET, setup);
    chk("drivers", 8'h00, {4'h0, drv});
    chk("decoded", 8'h00, {4'h0, dec});
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(rows_in[i]);
      cyc(2);
      chk("functions", {4'h0, rows_in[i][6:3]}, {4'h0, fn2, fn1});
      chk("decoded", {4'h0, rows_dec[i]}, {4'h0, dec});
    end
    $display("decode table test done");
    init_mode = 1'b0;
    host.send(LIO_SETUP_ADDR, 8'hFF, 1'b0);
    chk("wr_refused", 8'h01, {7'h00, wr_refused});
    chk("setup", 8'h48, setup);
    init_mode = 1'b1;
    par_on = 1'b1;
    wr(8'h5A);
    host.send(LIO_SETUP_ADDR, 8'h06, 1'b1);
    chk("wr_refused", 8'h01, {7'h00, wr_refused});
    chk("setup", 8'h5A, setup);
    // A write to a neighbouring register must pass by without any answer from this block.
    host.send(5'h08, 8'hFF, 1'b0);
    chk("wr_refused", 8'h00, {7'h00, wr_refused});
    chk("wr_done", 8'h00, {7'h00, wr_done});
    chk("setup", 8'h5A, setup);
    par_on = 1'b0;
    $display("refusal test done");
    req = 4'h9;
    wr(8'h00);
    cyc(3);
    chk("drivers", 8'h00, {4'h0, drv});
    wr(8'h06);
    cyc(3);
    chk("drivers", 8'h09, {4'h0, drv});
    req = 4'h6;
    cyc(3);
    chk("drivers", 8'h06, {4'h0, drv});
    wr(8'h86);
    mcu_ov = 1'b1;
    cyc(3);
    chk("drivers", 8'h04, {4'h0, drv});
    mcu_ov = 1'b0;
    aux_ov = 1'b1;
    cyc(3);
    chk("drivers", 8'h04, {4'h0, drv});
    wr(8'h06);
    cyc(3);
    chk("drivers", 8'h06, {4'h0, drv});
    aux_ov = 1'b0;
    $display("driver test done");
    req = 4'h8;
    wr(8'h02);
    cyc(3);
    lpm = 1'b1;
    cyc_en = 1'b1;
    cyc_act = 1'b1;
    req = 4'h4;
    cyc(3);
    chk("drivers", 8'h08, {4'h0, drv});
    cyc_act = 1'b0;
    cyc(3);
    chk("drivers", 8'h00, {4'h0, drv});
    wr(8'h03);
    cyc(3);
    chk("drivers", 8'h04, {4'h0, drv});
    cyc_act = 1'b1;
    cyc(3);
    chk("drivers", 8'h08, {4'h0, drv});
    cyc_act = 1'b0;
    cyc(3);
    chk("drivers", 8'h04, {4'h0, drv});
    // Low power without cyclic sensing keeps the drive saved before entry.
    cyc_en = 1'b0;
    cyc(3);
    chk("drivers", 8'h08, {4'h0, drv});
    $display("cyclic sense test done");
    lpm = 1'b0;
    cyc(3);
    chk("drivers", 8'h04, {4'h0, drv});
    req = 4'hC;
    cyc(3);
    chk("drivers", 8'h08, {4'h0, drv});
    $display("double request test done");
    ce = 1'b0;
    req = 4'h4;
    host.send(LIO_SETUP_ADDR, 8'h00, 1'b0);
    cyc(1);
    chk("setup", 8'h03, setup);
    chk("wr_done", 8'h00, {7'h00, wr_done});
    chk("drivers", 8'h08, {4'h0, drv});
    ce = 1'b1;
    cyc(2);
    chk("drivers", 8'h04, {4'h0, drv});
    $display("clock enable test done");
    // Reset must act even while the clock enable holds everything else.
    ce = 1'b0;
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    ce = 1'b1;
    chk("setup", LIO_SETUP_RESET, setup);
    chk("drivers", 8'h00, {4'h0, drv});
    wr(8'h08);
    cyc(2);
    chk("decoded", 8'h02, {4'h0, dec});
    $display("mid-run reset test done");
    test_done();
  end
endmodule : tb_lio_top

/* src/lio_drv_if.sv */
`timescale 1ns/100ps
interface lio_drv_if;
  logic high_req;
  logic low_req;
  logic out_en;
  logic off_force;
  logic cyc_sense;
  logic cyc_inv;
  logic low_power_mode;
  logic cyc_active;
  logic high_on;
  logic low_on;

  modport ctl
  (
    output high_req, low_req, out_en, off_force, cyc_sense, cyc_inv,
    output low_power_mode, cyc_active,
    input high_on, low_on
  );

  modport drv
  (
    input high_req, low_req, out_en, off_force, cyc_sense, cyc_inv,
    input low_power_mode, cyc_active,
    output high_on, low_on
  );
endinterface : lio_drv_if

/* src/lio_io_drv.sv */
`timescale 1ns/100ps
module lio_io_drv
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  lio_drv_if.drv pin
);
  import lio_pkg::*;

  logic saved_high;
  logic saved_low;
  logic next_high;
  logic next_low;
  lio_phase_type phase;
  wire req_low_clean = pin.low_req & ~pin.high_req;
  wire blocked = ~pin.out_en | pin.off_force;

  // Phase follows the supervisor's mode signals directly; nothing here times the period.
  assign phase = !pin.low_power_mode ? LIO_PH_RUN :
                 !pin.cyc_sense ? LIO_PH_HOLD :
                 pin.cyc_active ? LIO_PH_ACTIVE : LIO_PH_OFF;

  always_comb
  begin
    next_high = 1'b0;
    next_low = 1'b0;
    case (phase)
      LIO_PH_RUN:
      begin
        next_high = pin.high_req;
        next_low = req_low_clean;
      end
      LIO_PH_HOLD, LIO_PH_ACTIVE:
      begin
        next_high = saved_high;
        next_low = saved_low;
      end
      LIO_PH_OFF:
      begin
        next_high = pin.cyc_inv & saved_low;
        next_low = pin.cyc_inv & saved_high;
      end
      default:
      begin
        next_high = 1'b0;
        next_low = 1'b0;
      end
    endcase
    if (blocked)
    begin
      next_high = 1'b0;
      next_low = 1'b0;
    end
  end

  // The state before low power is captured every run cycle so it is current on entry.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      saved_high <= 1'b0;
      saved_low <= 1'b0;
      pin.high_on <= 1'b0;
      pin.low_on <= 1'b0;
    end
    else if (ce)
    begin
      if (phase == LIO_PH_RUN)
      begin
        saved_high <= pin.high_req;
        saved_low <= req_low_clean;
      end
      pin.high_on <= next_high;
      pin.low_on <= next_low;
    end
  end

  drv_block_a: assert property (@(posedge clk) disable iff (srst)
    (ce && blocked) |=> (!pin.high_on && !pin.low_on))
    else $error("driver on while disabled or forced off");

  cyc_active_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !blocked && phase == LIO_PH_ACTIVE) |=>
    (pin.high_on == $past(saved_high) && pin.low_on == $past(saved_low)))
    else $error("active phase did not restore saved drive");

  cyc_off_a: assert property (@(posedge clk) disable iff (srst)
    (ce && phase == LIO_PH_OFF && !pin.cyc_inv) |=> (!pin.high_on && !pin.low_on))
    else $error("off phase left a driver on");

  cyc_inv_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !blocked && phase == LIO_PH_OFF && pin.cyc_inv) |=>
    (pin.high_on == $past(saved_low) && pin.low_on == $past(saved_high)))
    else $error("off phase did not drive the opposite side");

  no_cross_a: assert property (@(posedge clk) disable iff (srst)
    !(pin.high_on && pin.low_on))
    else $error("both drivers on");
endmodule : lio_io_drv

/* src/lio_pkg.sv */
package lio_pkg;

  // Command address of the pin setup register in the first command byte.
  localparam logic [4:0] LIO_SETUP_ADDR = 5'h07;

  // Field positions inside the data byte.
  localparam int LIO_OVOFF_BIT = 7;
  localparam int LIO_PIN2_FN_HI = 6;
  localparam int LIO_PIN2_FN_LO = 5;
  localparam int LIO_PIN1_FN_HI = 4;
  localparam int LIO_PIN1_FN_LO = 3;
  localparam int LIO_IO1_EN_BIT = 2;
  localparam int LIO_IO0_EN_BIT = 1;
  localparam int LIO_CYC_INV_BIT = 0;

  localparam logic [7:0] LIO_SETUP_RESET = 8'h00;

  typedef enum logic [1:0]
  {
    LIO_FN_OFF = 2'b00,
    LIO_FN_MASTER = 2'b01,
    LIO_FN_HIGH_WAKE = 2'b10,
    LIO_FN_NA = 2'b11
  } lio_pin_fn_type;

  typedef enum logic [1:0]
  {
    LIO_PH_RUN = 2'b00,
    LIO_PH_HOLD = 2'b01,
    LIO_PH_ACTIVE = 2'b10,
    LIO_PH_OFF = 2'b11
  } lio_phase_type;

endpackage : lio_pkg

/* src/lio_top.sv */
`timescale 1ns/100ps
module lio_top
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic spi_wr_valid,
  input wire logic [4:0] spi_wr_addr,
  input wire logic spi_wr_parity,
  input wire logic [7:0] spi_wr_data,
  input wire logic parity_check_en,
  input wire logic init_mode,
  input wire logic low_power_mode,
  input wire logic cyclic_sense_en,
  input wire logic cyclic_active,
  input wire logic mcu_supply_ov,
  input wire logic auxiliary_supply_ov,
  input wire logic io0_high_req,
  input wire logic io0_low_req,
  input wire logic io1_high_req,
  input wire logic io1_low_req,
  output logic [7:0] lin_io_pin_setup,
  output lio_pkg::lio_pin_fn_type lin_pin1_function,
  output lio_pkg::lio_pin_fn_type lin_pin2_function,
  output logic lin1_master_switch,
  output logic lin1_high_wake,
  output logic lin2_master_switch,
  output logic lin2_high_wake,
  output logic io0_high_side_driver,
  output logic io0_low_side_driver,
  output logic io1_high_side_driver,
  output logic io1_low_side_driver,
  output logic wr_done,
  output logic wr_refused
);
  import lio_pkg::*;

  lio_drv_if io0_if ();
  lio_drv_if io1_if ();

  lio_pin_fn_type fn1;
  lio_pin_fn_type fn2;

  wire wr_hit = spi_wr_valid && (spi_wr_addr == LIO_SETUP_ADDR);
  // Even parity over address and data; with checking off the bit must be zero.
  wire parity_want = parity_check_en ? ^{spi_wr_addr, spi_wr_data} : 1'b0;
  wire parity_ok = (spi_wr_parity == parity_want);
  wire wr_accept = wr_hit && init_mode && parity_ok;
  wire wr_reject = wr_hit && !wr_accept;
  wire supply_ov = mcu_supply_ov | auxiliary_supply_ov;

  assign fn1 = lio_pin_fn_type'(lin_io_pin_setup[LIO_PIN1_FN_HI:LIO_PIN1_FN_LO]);
  assign fn2 = lio_pin_fn_type'(lin_io_pin_setup[LIO_PIN2_FN_HI:LIO_PIN2_FN_LO]);

  // The decoded pin flags lag the register by one cycle so every output leaves a flop.
  wire next_lin1_master = (fn1 == LIO_FN_MASTER);
  wire next_lin1_wake = (fn1 == LIO_FN_HIGH_WAKE);
  wire next_lin2_master = (fn2 == LIO_FN_MASTER);
  wire next_lin2_wake = (fn2 == LIO_FN_HIGH_WAKE);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lin_io_pin_setup <= LIO_SETUP_RESET;
      wr_done <= 1'b0;
      wr_refused <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_accept)
      begin
        lin_io_pin_setup <= spi_wr_data;
      end
      wr_done <= wr_accept;
      wr_refused <= wr_reject;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lin_pin1_function <= LIO_FN_OFF;
      lin_pin2_function <= LIO_FN_OFF;
      lin1_master_switch <= 1'b0;
      lin1_high_wake <= 1'b0;
      lin2_master_switch <= 1'b0;
      lin2_high_wake <= 1'b0;
    end
    else if (ce)
    begin
      lin_pin1_function <= fn1;
      lin_pin2_function <= fn2;
      lin1_master_switch <= next_lin1_master;
      lin1_high_wake <= next_lin1_wake;
      lin2_master_switch <= next_lin2_master;
      lin2_high_wake <= next_lin2_wake;
    end
  end

  // I/O-0 takes part in cyclic sensing; I/O-1 never does, so its low-power view is tied off.
  assign io0_if.high_req = io0_high_req;
  assign io0_if.low_req = io0_low_req;
  assign io0_if.out_en = lin_io_pin_setup[LIO_IO0_EN_BIT];
  assign io0_if.off_force = 1'b0;
  assign io0_if.cyc_sense = cyclic_sense_en;
  assign io0_if.cyc_inv = lin_io_pin_setup[LIO_CYC_INV_BIT];
  assign io0_if.low_power_mode = low_power_mode;
  assign io0_if.cyc_active = cyclic_active;

  assign io1_if.high_req = io1_high_req;
  assign io1_if.low_req = io1_low_req;
  assign io1_if.out_en = lin_io_pin_setup[LIO_IO1_EN_BIT];
  assign io1_if.off_force = lin_io_pin_setup[LIO_OVOFF_BIT] & supply_ov;
  assign io1_if.cyc_sense = 1'b0;
  assign io1_if.cyc_inv = 1'b0;
  assign io1_if.low_power_mode = 1'b0;
  assign io1_if.cyc_active = 1'b0;

  lio_io_drv u_io0
  (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin(io0_if)
  );

  lio_io_drv u_io1
  (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin(io1_if)
  );

  assign io0_high_side_driver = io0_if.high_on;
  assign io0_low_side_driver = io0_if.low_on;
  assign io1_high_side_driver = io1_if.high_on;
  assign io1_low_side_driver = io1_if.low_on;

  wr_load_a: assert property (@(posedge clk) disable iff (srst)
    (ce && wr_hit && init_mode && parity_ok) |=>
    (lin_io_pin_setup == $past(spi_wr_data) && wr_done))
    else $error("init write not stored");

  wr_block_a: assert property (@(posedge clk) disable iff (srst)
    (ce && wr_hit && !init_mode) |=>
    ($stable(lin_io_pin_setup) && wr_refused && !wr_done))
    else $error("write outside init changed setup");

  parity_block_a: assert property (@(posedge clk) disable iff (srst)
    (ce && wr_hit && init_mode && !parity_ok) |=>
    ($stable(lin_io_pin_setup) && wr_refused && !wr_done))
    else $error("write with bad parity changed setup");

  // Writes to other registers share the command path and must leave this one alone.
  other_addr_a: assert property (@(posedge clk) disable iff (srst)
    (ce && spi_wr_valid && spi_wr_addr != LIO_SETUP_ADDR) |=>
    ($stable(lin_io_pin_setup) && !wr_refused && !wr_done))
    else $error("write to another address touched setup");

  ce_hold_a: assert property (@(posedge clk) disable iff (srst)
    !ce |=> ($stable(lin_io_pin_setup) && $stable(wr_done) && $stable(lin1_master_switch)
      && $stable(io0_high_side_driver) && $stable(io1_low_side_driver)))
    else $error("state moved while clock enable low");

  setup_reset_a: assert property (@(posedge clk)
    srst |=> (lin_io_pin_setup == LIO_SETUP_RESET && !lin1_master_switch
      && !io0_high_side_driver && !io1_low_side_driver))
    else $error("reset did not clear setup");

  ov_off_a: assert property (@(posedge clk) disable iff (srst)
    (ce && lin_io_pin_setup[LIO_OVOFF_BIT] && supply_ov) |=>
    (!io1_high_side_driver && !io1_low_side_driver))
    else $error("I/O-1 on during overvoltage with shutoff set");

  ov_keep_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !lin_io_pin_setup[LIO_OVOFF_BIT] && lin_io_pin_setup[LIO_IO1_EN_BIT]
      && io1_high_req) |=> io1_high_side_driver)
    else $error("I/O-1 dropped without shutoff set");

  pin2_fn_a: assert property (@(posedge clk) disable iff (srst)
    ce ##1 ce |->
    (lin2_master_switch == ($past(fn2) == LIO_FN_MASTER)
      && lin2_high_wake == ($past(fn2) == LIO_FN_HIGH_WAKE)))
    else $error("pin 2 function decode wrong");

  pin1_na_a: assert property (@(posedge clk) disable iff (srst)
    (ce && fn1 == LIO_FN_NA) |=> (!lin1_master_switch && !lin1_high_wake))
    else $error("pin 1 code 11 enabled a function");

  pin1_fn_a: assert property (@(posedge clk) disable iff (srst)
    (ce && fn1 == LIO_FN_MASTER) |=> (lin1_master_switch && !lin1_high_wake))
    else $error("pin 1 master switch not selected");

  pin1_wake_a: assert property (@(posedge clk) disable iff (srst)
    (ce && fn1 == LIO_FN_HIGH_WAKE) |=> (lin1_high_wake && !lin1_master_switch))
    else $error("pin 1 wake input not selected");

  io1_dis_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !lin_io_pin_setup[LIO_IO1_EN_BIT]) |=>
    (!io1_high_side_driver && !io1_low_side_driver))
    else $error("I/O-1 driving while disabled");

  io0_en_a: assert property (@(posedge clk) disable iff (srst)
    (ce && lin_io_pin_setup[LIO_IO0_EN_BIT] && !low_power_mode && io0_high_req) |=>
    io0_high_side_driver)
    else $error("I/O-0 not driving when enabled");

  io0_dis_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !lin_io_pin_setup[LIO_IO0_EN_BIT]) |=>
    (!io0_high_side_driver && !io0_low_side_driver))
    else $error("I/O-0 driving while disabled");

  io0_inv_a: assert property (@(posedge clk) disable iff (srst)
    (ce && low_power_mode && cyclic_sense_en && !cyclic_active
      && !lin_io_pin_setup[LIO_CYC_INV_BIT]) |=>
    (!io0_high_side_driver && !io0_low_side_driver))
    else $error("I/O-0 on during off phase");
endmodule : lio_top
